// *** design/acfg_top.sv ***
// audio serial port clock, pdm and mode configuration registers with state readback
//
// The plain strobed port was decided locally.
module acfg_top (
	input wire logic core_clk, // 50 MHz system clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic [acfg_pkg::ADDR_W-1:0] reg_addr, // byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, valid the cycle after reg_rd
	input wire logic rx_fifo_rst_done, // datapath: receive fifo reset complete
	input wire logic tx_fifo_rst_done, // datapath: transmit fifo reset complete
	input wire logic tx_busy, // datapath: transmitter sending
	output logic rx_fifo_rst, // receive fifo reset level
	output logic tx_fifo_rst, // transmit fifo reset level
	output acfg_pkg::acfg_clk_t clk_cfg, // master clock settings
	output acfg_pkg::acfg_rate_t rate_cfg, // per-direction length and divider
	output acfg_pkg::acfg_pdm_t pdm_cfg, // decoded pdm settings
	output acfg_pkg::acfg_mode_t mode_cfg // camera and display modes
);
	logic [31:0] mclk_reg;
	logic [31:0] srate_reg;
	logic [31:0] pdm_reg;
	logic [31:0] pfreq_reg;
	logic [31:0] mode_reg;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [31:0] state_word;
	logic rx_back;
	logic tx_back;
	logic tx_idle_reg;
	logic rx_req;
	logic tx_req;
	logic [7:0] osr;

	// a write strobe to the fifo control word requests fifo resets, bits are not stored
	assign rx_req = reg_wr && (reg_addr == acfg_pkg::OFS_FIFO_CONTROL)
		&& reg_wdata[acfg_pkg::FIFO_RX_RST_BIT];
	assign tx_req = reg_wr && (reg_addr == acfg_pkg::OFS_FIFO_CONTROL)
		&& reg_wdata[acfg_pkg::FIFO_TX_RST_BIT];

	acfg_fifo_reset u_rx_rst (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.req(rx_req),
		.done(rx_fifo_rst_done),
		.fifo_rst(rx_fifo_rst),
		.busy(rx_back)
	);

	acfg_fifo_reset u_tx_rst (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.req(tx_req),
		.done(tx_fifo_rst_done),
		.fifo_rst(tx_fifo_rst),
		.busy(tx_back)
	);

	// idle sampled on the system clock; the datapath shares this clock
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx_idle_reg <= 1'b1;
		end else begin
			tx_idle_reg <= ~tx_busy;
		end
	end

	// masked stores keep reserved bits at zero so readback matches written fields
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mclk_reg <= acfg_pkg::RST_MCLK;
		end else if (reg_wr && reg_addr == acfg_pkg::OFS_MASTER_CLOCK_DIVIDER) begin
			mclk_reg <= reg_wdata & acfg_pkg::MASK_MCLK;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			srate_reg <= acfg_pkg::RST_SRATE;
		end else if (reg_wr && reg_addr == acfg_pkg::OFS_SAMPLE_RATE_CONFIG) begin
			srate_reg <= reg_wdata & acfg_pkg::MASK_SRATE;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pdm_reg <= acfg_pkg::RST_PDM;
		end else if (reg_wr && reg_addr == acfg_pkg::OFS_PDM_CONFIG) begin
			pdm_reg <= reg_wdata & acfg_pkg::MASK_PDM;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pfreq_reg <= acfg_pkg::RST_PFREQ;
		end else if (reg_wr && reg_addr == acfg_pkg::OFS_PDM_FREQUENCY_CONFIG) begin
			pfreq_reg <= reg_wdata & acfg_pkg::MASK_PFREQ;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			mode_reg <= acfg_pkg::RST_MODE;
		end else if (reg_wr && reg_addr == acfg_pkg::OFS_MODE_CONTROL) begin
			mode_reg <= reg_wdata & acfg_pkg::MASK_MODE;
		end
	end

	always_comb begin
		state_word = 32'h0000_0000;
		state_word[acfg_pkg::ST_RX_BACK_BIT] = rx_back;
		state_word[acfg_pkg::ST_TX_BACK_BIT] = tx_back;
		state_word[acfg_pkg::ST_TX_IDLE_BIT] = tx_idle_reg;
	end

	// port state has no write path at all, so writes there fall through
	always_comb begin
		if (reg_addr == acfg_pkg::OFS_MASTER_CLOCK_DIVIDER) begin
			rdata_next = mclk_reg;
		end else if (reg_addr == acfg_pkg::OFS_SAMPLE_RATE_CONFIG) begin
			rdata_next = srate_reg;
		end else if (reg_addr == acfg_pkg::OFS_PDM_CONFIG) begin
			rdata_next = pdm_reg;
		end else if (reg_addr == acfg_pkg::OFS_PDM_FREQUENCY_CONFIG) begin
			rdata_next = pfreq_reg;
		end else if (reg_addr == acfg_pkg::OFS_PORT_STATE) begin
			rdata_next = state_word;
		end else if (reg_addr == acfg_pkg::OFS_MODE_CONTROL) begin
			rdata_next = mode_reg;
		end else begin
			rdata_next = 32'h0000_0000;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rdata_reg <= 32'h0000_0000;
		end else if (reg_rd) begin
			rdata_reg <= rdata_next;
		end else begin
			rdata_reg <= 32'h0000_0000;
		end
	end

	assign reg_rdata = rdata_reg;

	assign clk_cfg.master_div_integer = mclk_reg[acfg_pkg::MCLK_INT_LSB +: 8];
	assign clk_cfg.master_div_numerator = mclk_reg[acfg_pkg::MCLK_NUM_LSB +: 6];
	assign clk_cfg.master_div_denominator = mclk_reg[acfg_pkg::MCLK_DEN_LSB +: 6];
	assign clk_cfg.audio_pll_clock_enable = mclk_reg[acfg_pkg::MCLK_APLL_BIT];

	assign rate_cfg.rx_sample_bit_length = srate_reg[acfg_pkg::SR_RX_BITS_LSB +: 6];
	assign rate_cfg.tx_sample_bit_length = srate_reg[acfg_pkg::SR_TX_BITS_LSB +: 6];
	assign rate_cfg.rx_bit_clock_divider = srate_reg[acfg_pkg::SR_RX_DIV_LSB +: 6];
	assign rate_cfg.tx_bit_clock_divider = srate_reg[acfg_pkg::SR_TX_DIV_LSB +: 6];

	assign osr = pdm_reg[acfg_pkg::PDM_OSR_LSB +: 8];
	assign pdm_cfg.tx_highpass_bypass = pdm_reg[acfg_pkg::PDM_HP_BYP_BIT];
	// decimation and interpolation handed out as ready-made rates
	assign pdm_cfg.rx_decimation = pdm_reg[acfg_pkg::PDM_DSR_BIT] ?
		8'(acfg_pkg::DEC_SLOW) : 8'(acfg_pkg::DEC_FAST);
	assign pdm_cfg.tx_interp_rate = 14'({6'h00, osr} * 14'(acfg_pkg::INTERP_BASE));
	// scale codes are already enumerated in halve, pass, double, quadruple order
	assign pdm_cfg.tx_modulator_input_scale =
		acfg_pkg::acfg_scale_t'(pdm_reg[acfg_pkg::PDM_SD_SHIFT_LSB +: 2]);
	assign pdm_cfg.tx_sinc_input_scale =
		acfg_pkg::acfg_scale_t'(pdm_reg[acfg_pkg::PDM_SINC_SHIFT_LSB +: 2]);
	assign pdm_cfg.tx_lowpass_input_scale =
		acfg_pkg::acfg_scale_t'(pdm_reg[acfg_pkg::PDM_LP_SHIFT_LSB +: 2]);
	assign pdm_cfg.tx_highpass_input_scale =
		acfg_pkg::acfg_scale_t'(pdm_reg[acfg_pkg::PDM_HP_SHIFT_LSB +: 2]);
	assign pdm_cfg.density_to_sample_enable = pdm_reg[acfg_pkg::PDM_D2S_EN_BIT];
	assign pdm_cfg.sample_to_density_enable = pdm_reg[acfg_pkg::PDM_S2D_EN_BIT];
	assign pdm_cfg.rx_pdm_enable = pdm_reg[acfg_pkg::PDM_RX_EN_BIT];
	assign pdm_cfg.tx_pdm_enable = pdm_reg[acfg_pkg::PDM_TX_EN_BIT];
	assign pdm_cfg.density_output_freq_param = pfreq_reg[acfg_pkg::PF_FP_LSB +: 10];
	assign pdm_cfg.sample_input_freq_param = pfreq_reg[acfg_pkg::PF_FS_LSB +: 10];

	assign mode_cfg.camera_internal_valid_enable =
		mode_reg[acfg_pkg::MODE_CAM_VALID_BIT];
	assign mode_cfg.camera_mode_enable = mode_reg[acfg_pkg::MODE_CAM_BIT];
	assign mode_cfg.external_converter_start_enable =
		mode_reg[acfg_pkg::MODE_EXT_START_BIT];
	assign mode_cfg.display_mode_enable = mode_reg[acfg_pkg::MODE_DISP_BIT];
	// duplication modes only act while display mode is on
	assign mode_cfg.display_pair_duplicate_enable =
		mode_reg[acfg_pkg::MODE_PAIR_DUP_BIT] & mode_reg[acfg_pkg::MODE_DISP_BIT];
	assign mode_cfg.display_write_twice_enable =
		mode_reg[acfg_pkg::MODE_WR_TWICE_BIT] & mode_reg[acfg_pkg::MODE_DISP_BIT];
endmodule

// *** design/acfg_pkg.sv ***
// package: register map, field layout, reset values and carriers for the audio port config block
package acfg_pkg;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_MASTER_CLOCK_DIVIDER = 8'h00ac;
	localparam logic [7:0] OFS_SAMPLE_RATE_CONFIG = 8'h00b0;
	localparam logic [7:0] OFS_PDM_CONFIG = 8'h00b4;
	localparam logic [7:0] OFS_PDM_FREQUENCY_CONFIG = 8'h00b8;
	localparam logic [7:0] OFS_PORT_STATE = 8'h00bc;
	localparam logic [7:0] OFS_MODE_CONTROL = 8'h00a8;
	localparam logic [7:0] OFS_FIFO_CONTROL = 8'h00a4;

	// writable bit masks per register
	localparam logic [31:0] MASK_MCLK = 32'h002f_ffff;
	localparam logic [31:0] MASK_SRATE = 32'h00ff_ffff;
	localparam logic [31:0] MASK_PDM = 32'h01ff_ffff;
	localparam logic [31:0] MASK_PFREQ = 32'h000f_ffff;
	localparam logic [31:0] MASK_MODE = 32'h0000_003f;

	// reset values
	localparam logic [31:0] RST_MCLK = 32'h0000_0004;
	localparam logic [31:0] RST_SRATE = 32'h0000_0000;
	localparam logic [31:0] RST_PDM = 32'h0000_0000;
	localparam logic [31:0] RST_PFREQ = 32'h0000_0000;
	localparam logic [31:0] RST_MODE = 32'h0000_0000;

	// master clock divider fields
	localparam int MCLK_INT_LSB = 0;
	localparam int MCLK_NUM_LSB = 8;
	localparam int MCLK_DEN_LSB = 14;
	localparam int MCLK_APLL_BIT = 21;
	// sample rate fields
	localparam int SR_TX_DIV_LSB = 0;
	localparam int SR_RX_DIV_LSB = 6;
	localparam int SR_TX_BITS_LSB = 12;
	localparam int SR_RX_BITS_LSB = 18;
	// pdm config fields
	localparam int PDM_TX_EN_BIT = 0;
	localparam int PDM_RX_EN_BIT = 1;
	localparam int PDM_S2D_EN_BIT = 2;
	localparam int PDM_D2S_EN_BIT = 3;
	localparam int PDM_OSR_LSB = 4;
	localparam int PDM_HP_SHIFT_LSB = 12;
	localparam int PDM_LP_SHIFT_LSB = 14;
	localparam int PDM_SINC_SHIFT_LSB = 16;
	localparam int PDM_SD_SHIFT_LSB = 18;
	localparam int PDM_DSR_BIT = 22;
	localparam int PDM_HP_BYP_BIT = 24;
	// pdm frequency fields
	localparam int PF_FS_LSB = 0;
	localparam int PF_FP_LSB = 10;
	// mode control fields
	localparam int MODE_CAM_VALID_BIT = 0;
	localparam int MODE_EXT_START_BIT = 1;
	localparam int MODE_DISP_BIT = 2;
	localparam int MODE_PAIR_DUP_BIT = 3;
	localparam int MODE_WR_TWICE_BIT = 4;
	localparam int MODE_CAM_BIT = 5;
	// fifo control / port state bits
	localparam int FIFO_RX_RST_BIT = 0;
	localparam int FIFO_TX_RST_BIT = 1;
	localparam int ST_RX_BACK_BIT = 0;
	localparam int ST_TX_BACK_BIT = 1;
	localparam int ST_TX_IDLE_BIT = 2;

	localparam int DEC_SLOW = 128;
	localparam int DEC_FAST = 64;
	localparam int INTERP_BASE = 64;

	typedef enum logic [1:0] {SCALE_HALF, SCALE_ONE, SCALE_TWO, SCALE_FOUR} acfg_scale_t;

	typedef struct packed {
		logic [7:0] master_div_integer;
		logic [5:0] master_div_numerator;
		logic [5:0] master_div_denominator;
		logic audio_pll_clock_enable;
	} acfg_clk_t;

	typedef struct packed {
		logic [5:0] rx_sample_bit_length;
		logic [5:0] tx_sample_bit_length;
		logic [5:0] rx_bit_clock_divider;
		logic [5:0] tx_bit_clock_divider;
	} acfg_rate_t;

	typedef struct packed {
		logic tx_highpass_bypass;
		logic [7:0] rx_decimation;
		logic [13:0] tx_interp_rate;
		acfg_scale_t tx_modulator_input_scale;
		acfg_scale_t tx_sinc_input_scale;
		acfg_scale_t tx_lowpass_input_scale;
		acfg_scale_t tx_highpass_input_scale;
		logic density_to_sample_enable;
		logic sample_to_density_enable;
		logic rx_pdm_enable;
		logic tx_pdm_enable;
		logic [9:0] density_output_freq_param;
		logic [9:0] sample_input_freq_param;
	} acfg_pdm_t;

	typedef struct packed {
		logic camera_internal_valid_enable;
		logic external_converter_start_enable;
		logic display_mode_enable;
		logic display_pair_duplicate_enable;
		logic display_write_twice_enable;
		logic camera_mode_enable;
	} acfg_mode_t;
endpackage

// *** design/acfg_fifo_reset.sv ***
// fifo reset tracker: holds a busy flag from request until the datapath acknowledges
module acfg_fifo_reset (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic req, // one-cycle reset request from software
	input wire logic done, // datapath reports reset complete, level or pulse
	output logic fifo_rst, // reset level to the fifo
	output logic busy // reads 1 while the reset is in progress
);
	logic busy_reg;

	// request beats a simultaneous done so a fresh reset is never dropped
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy_reg <= 1'b0;
		end else if (req) begin
			busy_reg <= 1'b1;
		end else if (done) begin
			busy_reg <= 1'b0;
		end
	end

	assign busy = busy_reg;
	assign fifo_rst = busy_reg;
endmodule

// *** test/acfg_assertions.sv ***
// checker: port-level timing and decoding of the audio port configuration block
module acfg_assertions (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire logic [acfg_pkg::ADDR_W-1:0] reg_addr, // byte address
	input wire logic [31:0] reg_wdata, // write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	input wire logic [31:0] reg_rdata, // read data
	input wire logic rx_fifo_rst_done, // rx fifo reset complete
	input wire logic tx_fifo_rst_done, // tx fifo reset complete
	input wire logic tx_busy, // transmitter sending
	input wire logic rx_fifo_rst, // rx fifo reset level
	input wire logic tx_fifo_rst, // tx fifo reset level
	input wire acfg_pkg::acfg_clk_t clk_cfg, // master clock settings
	input wire acfg_pkg::acfg_rate_t rate_cfg, // length and divider
	input wire acfg_pkg::acfg_pdm_t pdm_cfg, // pdm settings
	input wire acfg_pkg::acfg_mode_t mode_cfg // modes
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	logic wr_clk, wr_rate, wr_pdm, wr_fifo;
	assign wr_clk = reg_wr && reg_addr == acfg_pkg::OFS_MASTER_CLOCK_DIVIDER;
	assign wr_rate = reg_wr && reg_addr == acfg_pkg::OFS_SAMPLE_RATE_CONFIG;
	assign wr_pdm = reg_wr && reg_addr == acfg_pkg::OFS_PDM_CONFIG;
	assign wr_fifo = reg_wr && reg_addr == acfg_pkg::OFS_FIFO_CONTROL;
	a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("read data not zero outside read answer");
	a_clk_fields: assert property (wr_clk |=> clk_cfg == {
		$past(reg_wdata[7:0]), $past(reg_wdata[13:8]), $past(reg_wdata[19:14]),
		$past(reg_wdata[21])})
		else $error("clock divider fields wrong after write");
	a_rate_fields: assert property (wr_rate |=> rate_cfg == {
		$past(reg_wdata[23:18]), $past(reg_wdata[17:12]), $past(reg_wdata[11:6]),
		$past(reg_wdata[5:0])})
		else $error("rate fields wrong after write");
	a_decim_rate: assert property (wr_pdm |=> pdm_cfg.rx_decimation ==
		($past(reg_wdata[22]) ? 8'd128 : 8'd64))
		else $error("decimation rate wrong");
	a_interp_rate: assert property (wr_pdm |=>
		pdm_cfg.tx_interp_rate == 14'(64 * $past(reg_wdata[11:4])))
		else $error("interpolation rate wrong");
	a_bypass_bit: assert property (wr_pdm |=>
		pdm_cfg.tx_highpass_bypass == $past(reg_wdata[24]))
		else $error("highpass bypass wrong");
	a_scale_code: assert property (wr_pdm |=>
		pdm_cfg.tx_modulator_input_scale == $past(reg_wdata[19:18]))
		else $error("modulator scale wrong");
	a_rx_rst_hold: assert property (wr_fifo && reg_wdata[0] |=> rx_fifo_rst)
		else $error("rx fifo reset not raised by request");
	a_rx_rst_keep: assert property (rx_fifo_rst && !rx_fifo_rst_done |=> rx_fifo_rst)
		else $error("rx fifo reset dropped before done");
	a_tx_rst_clear: assert property (
		tx_fifo_rst && tx_fifo_rst_done && !wr_fifo |=> !tx_fifo_rst)
		else $error("tx fifo reset not cleared after done");
	a_dup_needs_disp: assert property (mode_cfg.display_pair_duplicate_enable
		|-> mode_cfg.display_mode_enable)
		else $error("pair duplicate active outside display mode");
endmodule

bind acfg_top acfg_assertions acfg_assertions_inst (.core_clk(core_clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .rx_fifo_rst_done(rx_fifo_rst_done),
	.tx_fifo_rst_done(tx_fifo_rst_done), .tx_busy(tx_busy), .rx_fifo_rst(rx_fifo_rst),
	.tx_fifo_rst(tx_fifo_rst), .clk_cfg(clk_cfg), .rate_cfg(rate_cfg), .pdm_cfg(pdm_cfg),
	.mode_cfg(mode_cfg));

// *** test/tb.sv ***
// testbench: register access sequences for the audio port configuration block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
	logic rx_done = 0, tx_done = 0, tx_busy = 0, rx_fifo_rst, tx_fifo_rst;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, v;
	acfg_pkg::acfg_clk_t clk_cfg;
	acfg_pkg::acfg_rate_t rate_cfg;
	acfg_pkg::acfg_pdm_t pdm_cfg;
	acfg_pkg::acfg_mode_t mode_cfg;
	int n_fail = 0, n_checks = 0;
	logic [7:0] ofs [5] = '{8'h00ac, 8'h00b0, 8'h00b4, 8'h00b8, 8'h00a8};
	logic [31:0] msk [5] = '{32'h002f_ffff, 32'h00ff_ffff, 32'h01ff_ffff, 32'h000f_ffff,
		32'h0000_003f};
	always #10 core_clk = ~core_clk;
	acfg_top acfg_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_fifo_rst_done(rx_done), .tx_fifo_rst_done(tx_done), .tx_busy(tx_busy),
		.rx_fifo_rst(rx_fifo_rst), .tx_fifo_rst(tx_fifo_rst), .clk_cfg(clk_cfg),
		.rate_cfg(rate_cfg), .pdm_cfg(pdm_cfg), .mode_cfg(mode_cfg));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 0;
		#1 d = reg_rdata;
	endtask
	task automatic do_reset();
		sys_rst <= 1;
		repeat (5) @(posedge core_clk);
		sys_rst <= 0;
	endtask
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200us;
		n_fail++;
		stop_test();
	end
	initial begin
		do_reset();
		for (int i = 0; i < 5; i++) begin
			rd(ofs[i], v);
			check(v, i == 0 ? 32'h0000_0004 : 32'h0000_0000);
			wr(ofs[i], 32'hffff_ffff);
			rd(ofs[i], v);
			check(v, msk[i]);
		end
		rd(8'h00bc, v);
		check(v, 32'h0000_0004);
		wr(8'h00bc, 32'h0000_0003);
		rd(8'h00bc, v);
		check(v, 32'h0000_0004);
		rd(8'h0010, v);
		check(v, 32'h0000_0000);
		wr(8'h00ac, 32'h0025_3a7b);
		check(32'(clk_cfg), {11'h000, 8'h7b, 6'h3a, 6'h14, 1'b1});
		wr(8'h00b0, 32'h0012_3456);
		check(32'(rate_cfg), 32'h0012_3456);
		wr(8'h00b4, 32'h0140_003f);
		check(pdm_cfg.rx_decimation, 32'd128);
		check(pdm_cfg.tx_interp_rate, 32'd192);
		check({pdm_cfg.tx_highpass_bypass, pdm_cfg.density_to_sample_enable,
			pdm_cfg.sample_to_density_enable, pdm_cfg.rx_pdm_enable, pdm_cfg.tx_pdm_enable},
			32'h0000_001f);
		for (int k = 0; k < 4; k++) begin
			wr(8'h00b4, 32'(k * 32'h0005_5000));
			check({pdm_cfg.tx_modulator_input_scale, pdm_cfg.tx_sinc_input_scale,
				pdm_cfg.tx_lowpass_input_scale, pdm_cfg.tx_highpass_input_scale},
				32'(k * 8'h55));
		end
		wr(8'h00b4, 32'h000e_4000);
		check({pdm_cfg.tx_modulator_input_scale, pdm_cfg.tx_sinc_input_scale,
			pdm_cfg.tx_lowpass_input_scale, pdm_cfg.tx_highpass_input_scale},
			32'h0000_00e4);
		check({pdm_cfg.rx_decimation, pdm_cfg.tx_highpass_bypass}, {8'd64, 1'b0});
		wr(8'h00b8, 32'h000a_bc12);
		check({pdm_cfg.density_output_freq_param, pdm_cfg.sample_input_freq_param},
			32'h000a_bc12);
		wr(8'h00a8, 32'h0000_0039);
		check(32'(mode_cfg), 32'h0000_0021);
		wr(8'h00a8, 32'h0000_001e);
		check(32'(mode_cfg), 32'h0000_001e);
		wr(8'h00a4, 32'h0000_0003);
		check({rx_fifo_rst, tx_fifo_rst}, 32'h0000_0003);
		rd(8'h00bc, v);
		check(v, 32'h0000_0007);
		@(posedge core_clk);
		rx_done <= 1;
		@(posedge core_clk);
		rx_done <= 0;
		rd(8'h00bc, v);
		check(v, 32'h0000_0006);
		check({rx_fifo_rst, tx_fifo_rst}, 32'h0000_0001);
		@(posedge core_clk);
		tx_done <= 1;
		tx_busy <= 1;
		@(posedge core_clk);
		tx_done <= 0;
		rd(8'h00bc, v);
		check(v, 32'h0000_0000);
		check({rx_fifo_rst, tx_fifo_rst}, 32'h0000_0000);
		@(posedge core_clk);
		tx_busy <= 0;
		do_reset();
		rd(8'h00ac, v);
		check(v, 32'h0000_0004);
		stop_test();
	end
endmodule
